// ==== cfsp_core.sv ====
// condition flags register and stack pointer with context sequencer
`include "cfsp_params.svh"

// Notes on behaviour
// RQ1: add and adc update nibble carry
// RQ2: sign flag copies result bit seven
// RQ3: zero flag tracks zero result
// RQ4: carry from arithmetic, shifts, set and clear
// RQ5: flag bit layout, top bits read one
// RQ6: priority bits decode to four levels
// RQ7: irq entry loads priority bits
// RQ8: whole flags pushable, bits individually writable
// RQ9: sp decrements after push, increments before pop
// RQ10: upper stack pointer byte fixed
// RQ11: reset and rsp set low byte ones
// RQ12: low stack byte loadable and readable
// RQ13: stack pointer wraps silently both ways
// RQ14: irq stores pc low first, reverse return
// RQ15: call two bytes, irq five bytes
// RQ16: program counter two eight-bit halves
// RQ17: second index register never stacked
// RQ18: context order pcl, pch, x, a, flags
module cfsp_core (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire cfsp_pkg::cfsp_alu_t alu,
  input  wire logic              flags_wr,
  input  wire logic [7:0]        flags_wdata,
  input  wire logic              prio_wr,
  input  wire logic [1:0]        prio_wdata,
  input  wire logic              irq_enter,
  input  wire logic [1:0]        software_priority_regs,
  input  wire logic              irq_return,
  input  wire logic              call_start,
  input  wire logic              ret_start,
  input  wire logic              push_byte,
  input  wire logic              pop_byte,
  input  wire logic              reset_stack_instr,
  input  wire logic              load_instr,
  input  wire logic [7:0]        load_data,
  input  wire logic [15:0]       program_counter,
  input  wire logic [7:0]        index_x,
  input  wire logic [7:0]        accum,
  input  wire logic [7:0]        mem_rdata,
  output logic [7:0]             condition_flags,
  output logic [15:0]            stack_pointer,
  output logic [1:0]             priority_level,
  output logic                   irq_disabled,
  output logic                   stack_busy,
  output logic                   mem_we,
  output logic [15:0]            mem_addr,
  output logic [7:0]             mem_wdata,
  output logic                   pop_valid,
  output logic [7:0]             pop_data
);
  import cfsp_pkg::*;

  // ==========================================================
  // flags register
  logic [7:0] flags_q;
  logic [7:0] next_flags;
  logic       seq_pop_flags;
  logic [7:0] seq_pop_flag_val;

  always_comb begin
    next_flags = flags_q;
    case (alu.op)
      CFSP_OP_ADD, CFSP_OP_ADC: begin
        next_flags[`CFSP_BIT_NIBBLE] = alu.nibble_carry; // RQ1
        next_flags[`CFSP_BIT_CARRY]  = alu.carry_out;    // RQ4
        next_flags[`CFSP_BIT_SIGN]   = alu.result[7];    // RQ2
        next_flags[`CFSP_BIT_ZERO]   = alu.result == 8'h00; // RQ3
      end
      CFSP_OP_SUB, CFSP_OP_SHIFT: begin
        next_flags[`CFSP_BIT_CARRY] = alu.carry_out;     // RQ4
        next_flags[`CFSP_BIT_SIGN]  = alu.result[7];     // RQ2
        next_flags[`CFSP_BIT_ZERO]  = alu.result == 8'h00; // RQ3
      end
      CFSP_OP_LOGIC, CFSP_OP_MOVE: begin
        next_flags[`CFSP_BIT_SIGN] = alu.result[7];      // RQ2
        next_flags[`CFSP_BIT_ZERO] = alu.result == 8'h00; // RQ3
      end
      CFSP_OP_BTJ: next_flags[`CFSP_BIT_CARRY] = alu.carry_out; // RQ4
      CFSP_OP_SCF: next_flags[`CFSP_BIT_CARRY] = 1'b1;    // RQ4
      CFSP_OP_RCF: next_flags[`CFSP_BIT_CARRY] = 1'b0;    // RQ4
      default: ;
    endcase
    if (flags_wr)
      next_flags = flags_wdata;                           // RQ8
    if (seq_pop_flags)
      next_flags = seq_pop_flag_val;                      // RQ8
    if (prio_wr) begin
      next_flags[`CFSP_BIT_PRIO_HIGH] = prio_wdata[1];    // RQ7
      next_flags[`CFSP_BIT_PRIO_LOW]  = prio_wdata[0];
    end
    if (irq_enter) begin
      next_flags[`CFSP_BIT_PRIO_HIGH] = software_priority_regs[1]; // RQ7
      next_flags[`CFSP_BIT_PRIO_LOW]  = software_priority_regs[0];
    end
    next_flags = next_flags | `CFSP_FLAGS_FIXED;          // RQ5
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      flags_q <= `CFSP_FLAGS_RESET;                       // RQ5
    else
      flags_q <= next_flags;
  end

  assign condition_flags = flags_q;

  // level 0 lowest .. level 3 masks interrupts
  function automatic logic [1:0] prio_decode(input logic [7:0] f);
    case ({f[`CFSP_BIT_PRIO_HIGH], f[`CFSP_BIT_PRIO_LOW]})
      2'h2:    prio_decode = 2'h0;
      2'h1:    prio_decode = 2'h1;
      2'h0:    prio_decode = 2'h2;
      default: prio_decode = 2'h3;
    endcase
  endfunction

  assign priority_level = prio_decode(flags_q);           // RQ6
  assign irq_disabled   = prio_decode(flags_q) == 2'h3;   // RQ6

  // ==========================================================
  // stack pointer and context sequencer
  cfsp_state_t state, next_state;
  logic [7:0]  sp_low, next_sp_low;
  logic [2:0]  cnt, next_cnt;
  logic [39:0] ctx, next_ctx;
  logic        next_we;
  logic [7:0]  next_wdata;
  logic        next_pop_valid;
  logic [7:0]  next_pop_data;
  logic [15:0] next_addr;
  logic        pop_pending;
  logic        pop_is_flags;
  logic        rd_d, next_rd;
  logic        rd_flags_d, next_rd_flags;

  // irq context, pushed lowest byte first: pcl, pch, x, a, flags
  wire [39:0] irq_ctx = {flags_q, accum, index_x,
                         program_counter[15:8], program_counter[7:0]}; // RQ17 RQ18

  always_comb begin
    next_state     = state;
    next_sp_low    = sp_low;
    next_cnt       = cnt;
    next_ctx       = ctx;
    next_we        = 1'b0;
    next_wdata     = 8'h00;
    next_pop_valid = 1'b0;
    next_pop_data  = 8'h00;
    next_addr      = {`CFSP_SP_HIGH, sp_low};
    seq_pop_flags    = 1'b0;
    seq_pop_flag_val = 8'h00;
    // each pop cycle issues one read at the incremented address
    next_rd          = state == CFSP_ST_POP || state == CFSP_ST_INTERRUPT_RETURN_INSTR;
    next_rd_flags    = state == CFSP_ST_INTERRUPT_RETURN_INSTR && cnt == `CFSP_IRQ_BYTES;
    case (state)
      CFSP_ST_IDLE: begin
        if (reset_stack_instr)
          next_sp_low = `CFSP_SP_LOW_RESET;               // RQ11
        else if (load_instr)
          next_sp_low = load_data;                        // RQ12
        else if (irq_enter) begin
          next_ctx   = irq_ctx;
          next_cnt   = `CFSP_IRQ_BYTES;                   // RQ15
          next_state = CFSP_ST_IRQ;
        end else if (call_start) begin
          next_ctx   = {24'h000000, program_counter[15:8],
                        program_counter[7:0]};            // RQ16
          next_cnt   = `CFSP_CALL_BYTES;                  // RQ15
          next_state = CFSP_ST_CALL;
        end else if (irq_return) begin
          next_cnt   = `CFSP_IRQ_BYTES;
          next_state = CFSP_ST_INTERRUPT_RETURN_INSTR;
        end else if (ret_start) begin
          next_cnt   = `CFSP_CALL_BYTES;
          next_state = CFSP_ST_POP;
        end else if (push_byte) begin
          next_we     = 1'b1;
          next_wdata  = accum;
          next_sp_low = sp_low - 8'h01;                   // RQ9 RQ13
        end else if (pop_byte) begin
          // increment happens once, in the pop state
          next_cnt    = 3'h1;
          next_state  = CFSP_ST_POP;
        end
      end
      CFSP_ST_IRQ, CFSP_ST_CALL: begin
        // write at sp, then decrement: pcl lands highest
        next_we     = 1'b1;
        next_wdata  = ctx[7:0];                           // RQ14
        next_ctx    = {8'h00, ctx[39:8]};
        next_sp_low = sp_low - 8'h01;                     // RQ9 RQ13
        next_cnt    = cnt - 3'h1;
        if (cnt == 3'h1)
          next_state = CFSP_ST_IDLE;
      end
      CFSP_ST_POP, CFSP_ST_INTERRUPT_RETURN_INSTR: begin
        // increment first, read at new address
        next_sp_low = sp_low + 8'h01;                     // RQ9 RQ13
        next_addr   = {`CFSP_SP_HIGH, sp_low + 8'h01};
        next_cnt    = cnt - 3'h1;
        if (cnt == 3'h1)
          next_state = CFSP_ST_IDLE;
      end
      default: next_state = CFSP_ST_IDLE;
    endcase
    // data read at previous address returns this cycle
    if (pop_pending) begin
      next_pop_valid = 1'b1;
      next_pop_data  = mem_rdata;
      if (pop_is_flags) begin
        seq_pop_flags    = 1'b1;                          // RQ14
        seq_pop_flag_val = mem_rdata;
      end
    end
  end

  // a read issued on the last edge returns its byte this cycle
  assign pop_pending  = rd_d;
  assign pop_is_flags = rd_flags_d;                       // RQ14

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= CFSP_ST_IDLE;
      sp_low    <= `CFSP_SP_LOW_RESET;                    // RQ11
      cnt       <= 3'h0;
      ctx       <= 40'h0;
      mem_we    <= 1'b0;
      mem_wdata <= 8'h00;
      mem_addr  <= {`CFSP_SP_HIGH, `CFSP_SP_LOW_RESET};
      pop_valid <= 1'b0;
      pop_data  <= 8'h00;
      rd_flags_d <= 1'b0;
      rd_d      <= 1'b0;
    end else begin
      state     <= next_state;
      sp_low    <= next_sp_low;
      cnt       <= next_cnt;
      ctx       <= next_ctx;
      mem_we    <= next_we;
      mem_wdata <= next_wdata;
      mem_addr  <= next_addr;
      pop_valid <= next_pop_valid;
      pop_data  <= next_pop_data;
      rd_d      <= next_rd;
      rd_flags_d <= next_rd_flags;
    end
  end

  assign stack_pointer = {`CFSP_SP_HIGH, sp_low};         // RQ10
  assign stack_busy    = state != CFSP_ST_IDLE;

  // ==========================================================
  // checks
  a_top_bits_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags_q[7:6] == 2'h3) else $error("flag top bits not one"); // RQ5
  a_sp_high_fixed: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stack_pointer[15:8] == `CFSP_SP_HIGH) else $error("sp high moved"); // RQ10
  a_rsp_sets_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == CFSP_ST_IDLE && reset_stack_instr |=> sp_low == 8'hFF)
    else $error("rsp failed"); // RQ11
  a_irq_five_bytes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == CFSP_ST_IDLE && irq_enter && !reset_stack_instr && !load_instr
    |=> ##5 sp_low == $past(sp_low, 6) - 8'h05)
    else $error("irq not five bytes"); // RQ15
  a_push_decrement: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == CFSP_ST_IDLE && push_byte && !reset_stack_instr && !load_instr
    && !irq_enter && !call_start && !irq_return && !ret_start
    |=> sp_low == $past(sp_low) - 8'h01 && mem_we)
    else $error("push did not decrement"); // RQ9
  a_zero_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    alu.op == CFSP_OP_MOVE && !flags_wr && !seq_pop_flags
    |=> flags_q[`CFSP_BIT_ZERO] == ($past(alu.result) == 8'h00))
    else $error("zero flag wrong"); // RQ3
  a_sign_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    alu.op == CFSP_OP_LOGIC && !flags_wr && !seq_pop_flags
    |=> flags_q[`CFSP_BIT_SIGN] == $past(alu.result[7]))
    else $error("sign flag wrong"); // RQ2
  a_irq_prio_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq_enter |=> {flags_q[5], flags_q[3]} == $past(software_priority_regs))
    else $error("priority not loaded"); // RQ7
  a_scf_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    alu.op == CFSP_OP_SCF && !flags_wr && !seq_pop_flags
    |=> flags_q[0]) else $error("scf failed"); // RQ4
  a_pop_increment: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == CFSP_ST_IDLE && pop_byte && !reset_stack_instr && !load_instr
    && !irq_enter && !call_start && !irq_return && !ret_start
    |=> ##1 sp_low == $past(sp_low, 2) + 8'h01)
    else $error("pop did not increment"); // RQ9
  a_call_two_bytes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == CFSP_ST_IDLE && call_start && !reset_stack_instr && !load_instr
    && !irq_enter |=> ##2 sp_low == $past(sp_low, 3) - 8'h02)
    else $error("call not two bytes"); // RQ15
  a_interrupt_return_instr_flags_back: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pop_is_flags && !prio_wr && !irq_enter
    |=> flags_q == ($past(mem_rdata) | 8'hC0))
    else $error("flags not restored"); // RQ14
endmodule

// ==== cfsp_params.svh ====
// offsets, field positions, reset values and fixed values of flags and stack
`ifndef CFSP_PARAMS_SVH
`define CFSP_PARAMS_SVH
`define CFSP_BIT_CARRY      0
`define CFSP_BIT_ZERO       1
`define CFSP_BIT_SIGN       2
`define CFSP_BIT_PRIO_LOW   3
`define CFSP_BIT_NIBBLE     4
`define CFSP_BIT_PRIO_HIGH  5
`define CFSP_FLAGS_RESET    8'hE8
`define CFSP_FLAGS_FIXED    8'hC0
`define CFSP_SP_HIGH        8'h01
`define CFSP_SP_LOW_RESET   8'hFF
`define CFSP_CALL_BYTES     3'h2
`define CFSP_IRQ_BYTES      3'h5
`endif

// ==== cfsp_pkg.sv ====
// types shared by the flag and stack pointer block
package cfsp_pkg;
  typedef enum logic [3:0] {
    CFSP_OP_NONE  = 4'h0,
    CFSP_OP_ADD   = 4'h1,
    CFSP_OP_ADC   = 4'h2,
    CFSP_OP_SUB   = 4'h3,
    CFSP_OP_LOGIC = 4'h4,
    CFSP_OP_MOVE  = 4'h5,
    CFSP_OP_SHIFT = 4'h6,
    CFSP_OP_BTJ   = 4'h7,
    CFSP_OP_SCF   = 4'h8,
    CFSP_OP_RCF   = 4'h9
  } cfsp_op_t;

  typedef struct packed {
    cfsp_op_t   op;
    logic [7:0] result;
    logic       carry_out;
    logic       nibble_carry;
  } cfsp_alu_t;

  typedef enum logic [5:0] {
    CFSP_ST_IDLE  = 6'h01,
    CFSP_ST_PUSH  = 6'h02,
    CFSP_ST_POP   = 6'h04,
    CFSP_ST_IRQ   = 6'h08,
    CFSP_ST_INTERRUPT_RETURN_INSTR  = 6'h10,
    CFSP_ST_CALL  = 6'h20
  } cfsp_state_t;
endpackage

// ==== cfsp_stack_mem.sv ====
// stack memory model answering the block's byte reads and writes
module cfsp_stack_mem (
  input  wire logic        clk_sys,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [256];
  // scrambled contents so stale reads never look plausible
  initial for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'hA5;
  // only the low address byte selects a location
  always @(posedge clk_sys) begin
    if (mem_we) ram[mem_addr[7:0]] <= mem_wdata;
  end
  assign mem_rdata = ram[mem_addr[7:0]];
endmodule

// ==== tb_cpu_flags_and_stack_pointer.sv ====
// self-checking bench for the flag register and stack pointer
module tb_cpu_flags_and_stack_pointer;
  timeunit 1ns;
  timeprecision 1ps;
  import cfsp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  cfsp_alu_t alu = '0;
  logic [9:0] stb = '0;
  logic [7:0] flags_wdata = '0, load_data = '0, index_x = '0, accum = '0;
  logic [1:0] prio_wdata = '0, spr = '0;
  logic [15:0] program_counter = '0;
  logic [7:0] condition_flags, mem_wdata, pop_data, mem_rdata, mf, d;
  logic [15:0] stack_pointer, mem_addr;
  logic [1:0] priority_level;
  logic irq_disabled, stack_busy, mem_we, pop_valid;
  logic [31:0] lfsr = 32'h783581EB;
  logic [23:0] wr_q [$];
  logic [7:0] pd_q [$];
  logic [7:0] ctx [5];
  cfsp_alu_t a;
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [1:0] LVL [4] = '{2'h2, 2'h1, 2'h0, 2'h3};

  always #4 clk_sys = ~clk_sys;

  cfsp_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .alu(alu),
    .flags_wr(stb[0]), .flags_wdata(flags_wdata), .prio_wr(stb[1]),
    .prio_wdata(prio_wdata), .irq_enter(stb[2]),
    .software_priority_regs(spr), .irq_return(stb[3]),
    .call_start(stb[4]), .ret_start(stb[5]), .push_byte(stb[6]),
    .pop_byte(stb[7]), .reset_stack_instr(stb[8]), .load_instr(stb[9]),
    .load_data(load_data), .program_counter(program_counter),
    .index_x(index_x), .accum(accum), .mem_rdata(mem_rdata),
    .condition_flags(condition_flags), .stack_pointer(stack_pointer),
    .priority_level(priority_level), .irq_disabled(irq_disabled),
    .stack_busy(stack_busy), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .pop_valid(pop_valid), .pop_data(pop_data));

  cfsp_stack_mem mem (.clk_sys(clk_sys), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  always @(posedge clk_sys) begin
    if (mem_we === 1'b1) wr_q.push_back({mem_addr, mem_wdata});
    if (pop_valid === 1'b1) pd_q.push_back(pop_data);
  end

  function automatic logic [31:0] rnd();
    lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'hA3000000 : lfsr >> 1;
    return lfsr;
  endfunction

  function automatic logic [7:0] exp_flags(logic [7:0] f, cfsp_alu_t x);
    logic [7:0] r;
    r = f;
    if (x.op inside {CFSP_OP_ADD, CFSP_OP_ADC, CFSP_OP_SUB, CFSP_OP_LOGIC,
                     CFSP_OP_MOVE, CFSP_OP_SHIFT}) begin
      r[2] = x.result[7];
      r[1] = (x.result == 8'h00);
    end
    if (x.op inside {CFSP_OP_ADD, CFSP_OP_ADC}) r[4] = x.nibble_carry;
    if (x.op inside {CFSP_OP_ADD, CFSP_OP_ADC, CFSP_OP_SUB, CFSP_OP_SHIFT,
                     CFSP_OP_BTJ}) r[0] = x.carry_out;
    if (x.op == CFSP_OP_SCF) r[0] = 1'b1;
    if (x.op == CFSP_OP_RCF) r[0] = 1'b0;
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, exp, mask = 16'hFFFF);
    n_tests++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobe with its data applied on the same edge
  task automatic pulse(input int i, input logic [7:0] v = 8'h00);
    @(posedge clk_sys);
    stb <= 10'(1 << i);
    flags_wdata <= v;
    load_data <= v;
    prio_wdata <= v[1:0];
    spr <= v[1:0];
    @(posedge clk_sys);
    stb <= '0;
  endtask

  task automatic idle();
    int n;
    n = 0;
    #1;
    while (stack_busy !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 50) chk(16'(stack_busy), 16'h0000);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic give_verdict();
    $display("Counts: %0d errors, %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    chk(16'h0000, 16'h0001);
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    program_counter <= 16'(rnd());
    index_x <= 8'(rnd());
    accum <= 8'(rnd());
    @(posedge clk_sys);
    #1;
    chk(condition_flags, 16'h00E8, 16'h00E8);
    chk(stack_pointer, 16'h01FF);
    mf = 8'hE8;
    for (int k = 0; k < 200; k++) begin
      d = 8'(rnd());
      a.op = cfsp_op_t'(4'(rnd() % 10));
      a.result = (k % 8 == 0) ? 8'h00 : d;
      a.carry_out = lfsr[9];
      a.nibble_carry = lfsr[17];
      @(posedge clk_sys);
      alu <= a;
      @(posedge clk_sys);
      alu <= '0;
      #1;
      mf = exp_flags(mf, a);
      chk(condition_flags, mf);
    end
    for (int v = 0; v < 4; v++) begin
      pulse(1, 8'(v));
      #1;
      mf[5] = v[1];
      mf[3] = v[0];
      chk(condition_flags, mf);
      chk(priority_level, LVL[v]);
      chk(16'(irq_disabled), 16'(v == 3));
    end
    d = 8'(rnd());
    pulse(0, d);
    #1;
    mf = d | 8'hC0;
    chk(condition_flags, mf);
    pulse(9, 8'h02);
    idle();
    chk(stack_pointer, 16'h0102);
    ctx = '{program_counter[7:0], program_counter[15:8], index_x, accum, mf};
    wr_q.delete();
    pulse(2, 8'h01);
    pulse(6);
    idle();
    chk(condition_flags, 16'h0008, 16'h0028);
    chk(16'(wr_q.size()), 16'h0005);
    foreach (wr_q[i]) begin
      chk(wr_q[i][23:8], {8'h01, 8'h02 - 8'(i)});
      chk(16'(wr_q[i][7:0]), 16'(ctx[i]), i == 4 ? 16'h00D7 : 16'hFFFF);
    end
    chk(stack_pointer, 16'h01FD);
    pulse(0, ~mf);
    pulse(3);
    idle();
    chk(stack_pointer, 16'h0102);
    chk(condition_flags, 16'(mf), 16'h00D7);
    wr_q.delete();
    pulse(4);
    idle();
    chk(16'(wr_q.size()), 16'h0002);
    if (wr_q.size() == 2) chk(wr_q[1][23:8], 16'h0101);
    chk(stack_pointer, 16'h0100);
    pulse(5);
    idle();
    chk(stack_pointer, 16'h0102);
    pulse(9, 8'h00);
    wr_q.delete();
    pulse(6);
    idle();
    chk(16'(wr_q.size()), 16'h0001);
    if (wr_q.size() == 1) chk(16'(wr_q[0]), {8'h00, accum});
    chk(stack_pointer, 16'h01FF);
    pd_q.delete();
    pulse(7);
    idle();
    chk(stack_pointer, 16'h0100);
    chk(16'(pd_q.size()), 16'h0001);
    if (pd_q.size() == 1) chk(16'(pd_q[0]), 16'(accum));
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk(condition_flags, 16'h00E8, 16'h00E8);
    chk(stack_pointer, 16'h01FF);
    give_verdict();
  end
endmodule
